// ===== core/icp_ctrl_port.sv
// two-wire slave control port with power-management register
// Operation
// - answer address 0011000, lsb selects read/write
// - one bit per scl, sda change high = condition
// - start/stop are sda edges while scl high
// - stop honoured except in start's high pulse
// - pull sda low whole ninth pulse after byte
// - second byte sets pointer, data stored then increment
// - start then read address: pointer to zero
// - pointer increments per sent byte, stop restarts
// - pointer preset then repeated start reads there
// - read bits valid when scl rises
// - works with scl up to 400 kHz
// - power register bit layout, shutdown control
// - left line powers preamp, both amps outside mono modes, routes right if alone
// - right line powers preamp, and right amp outside mono modes
// - left dac powers left amp; outside mono modes powers right amp, feeds it if alone
// - read-only fixed revision register
module icp_ctrl_port #(
  parameter logic [7:0] REVISION_CODE = icp_pkg::REV_DEFAULT,
  parameter int         SCL_HALF_CYC  = icp_pkg::SCL_HALF_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_n,
  input  wire logic [2:0]    headphone_amp_mode,
  output icp_pkg::icp_pwr_reg_t power_control,
  output icp_pkg::icp_power_t   power_state
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // scl half period must outlast sync latency
  if (SCL_HALF_CYC < icp_pkg::MIN_HALF_CYC) begin : g_rate_chk
    $error("scl too fast for core clock sampling");
  end

  // ----------------------------------------------------------------
  // line conditioning
  // ----------------------------------------------------------------
  logic scl_hi, sda_hi, start_p, stop_p, scl_rise, scl_fall;

  icp_line_sync u_sync (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .scl_pin     (scl_in),
    .sda_pin     (sda_in),
    .scl_hi      (scl_hi),
    .sda_hi      (sda_hi),
    .start_pulse (start_p),
    .stop_pulse  (stop_p),
    .scl_rise    (scl_rise),
    .scl_fall    (scl_fall)
  );

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // revision register is constant, writes ignored
  function automatic logic [7:0] reg_read(
    input logic [7:0]           idx,
    input icp_pkg::icp_pwr_reg_t pwr
  );
    logic [7:0] val;
    val = 8'h00;
    if (idx == icp_pkg::REG_PWR) begin
      val = pwr;
    end else if (idx == icp_pkg::REG_REV) begin
      val = REVISION_CODE;
    end
    return val;
  endfunction

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  icp_pkg::icp_state_t   st_r, st_nxt;
  logic [3:0]            bcnt_r, bcnt_nxt;
  logic [7:0]            shf_r, shf_nxt;
  logic [7:0]            ptr_r, ptr_nxt;
  logic                  rw_r, rw_nxt;       // 1 = read transfer
  logic                  first_r, first_nxt; // next write byte is pointer
  logic                  preset_r, preset_nxt;
  logic                  sthi_r, sthi_nxt;   // start in this high pulse
  logic                  more_r, more_nxt;   // master acked last byte
  logic                  oe_n_r, oe_n_nxt;
  icp_pkg::icp_pwr_reg_t pwr_r, pwr_nxt;
  logic                  wr_stb;
  logic                  rd_addr_hit;
  logic [7:0]            tx;

  // bus sequencing, one decision per synchronised scl edge
  always_comb begin
    st_nxt      = st_r;
    bcnt_nxt    = bcnt_r;
    shf_nxt     = shf_r;
    ptr_nxt     = ptr_r;
    rw_nxt      = rw_r;
    first_nxt   = first_r;
    preset_nxt  = preset_r;
    sthi_nxt    = sthi_r;
    more_nxt    = more_r;
    oe_n_nxt    = oe_n_r;
    pwr_nxt     = pwr_r;
    wr_stb      = 1'b0;
    rd_addr_hit = 1'b0;
    tx          = reg_read(ptr_r, pwr_r);
    if (start_p) begin
      // start or repeated start opens an address phase
      st_nxt   = icp_pkg::ST_ADDR;
      bcnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
      sthi_nxt = 1'b1;
    end else if (stop_p && !sthi_r) begin
      // stop aborts anywhere, pointer preset forgotten
      st_nxt     = icp_pkg::ST_IDLE;
      oe_n_nxt   = 1'b1;
      preset_nxt = 1'b0;
    end else begin
      if (scl_fall) begin
        sthi_nxt = 1'b0;
      end
      unique case (st_r)
        icp_pkg::ST_IDLE, icp_pkg::ST_IGN: begin
          oe_n_nxt = 1'b1;
        end
        icp_pkg::ST_ADDR, icp_pkg::ST_WDAT: begin
          // data sampled on scl rise only
          if (scl_rise) begin
            shf_nxt  = {shf_r[6:0], sda_hi};
            bcnt_nxt = bcnt_r + 4'h1;
          end else if (scl_fall && bcnt_r == icp_pkg::BYTE_BITS) begin
            bcnt_nxt = 4'h0;
            if (st_r == icp_pkg::ST_ADDR) begin
              // compare upper seven bits, lsb is direction
              if (shf_r[7:1] == icp_pkg::SLAVE_ADDR) begin
                rw_nxt    = shf_r[0];
                first_nxt = ~shf_r[0];
                oe_n_nxt  = 1'b0;
                st_nxt    = icp_pkg::ST_ACK;
                // direct read restarts at register zero
                if (shf_r[0] && !preset_r) begin
                  rd_addr_hit = 1'b1;
                  ptr_nxt     = icp_pkg::PTR_RESET;
                end
              end else begin
                st_nxt = icp_pkg::ST_IGN;
              end
            end else begin
              // pointer byte first, then store and step
              if (first_r) begin
                ptr_nxt    = shf_r;
                preset_nxt = 1'b1;
                first_nxt  = 1'b0;
              end else begin
                wr_stb  = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
                if (ptr_r == icp_pkg::REG_PWR) begin
                  pwr_nxt = shf_r & icp_pkg::PWR_WMASK;
                end
              end
              oe_n_nxt = 1'b0;
              st_nxt   = icp_pkg::ST_ACK;
            end
          end
        end
        icp_pkg::ST_ACK: begin
          // low held until the ninth pulse falls
          if (scl_fall) begin
            bcnt_nxt = 4'h0;
            if (rw_r) begin
              // first bit driven while scl low
              oe_n_nxt = tx[7];
              shf_nxt  = {tx[6:0], 1'b0};
              st_nxt   = icp_pkg::ST_RDAT;
            end else begin
              oe_n_nxt = 1'b1;
              st_nxt   = icp_pkg::ST_WDAT;
            end
          end
        end
        icp_pkg::ST_RDAT: begin
          if (scl_rise) begin
            bcnt_nxt = bcnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bcnt_r == icp_pkg::BYTE_BITS) begin
              // step pointer after each sent byte
              ptr_nxt  = ptr_r + 8'h01;
              oe_n_nxt = 1'b1;
              bcnt_nxt = 4'h0;
              st_nxt   = icp_pkg::ST_RACK;
            end else begin
              // change sda only after scl falls
              oe_n_nxt = shf_r[7];
              shf_nxt  = {shf_r[6:0], 1'b0};
            end
          end
        end
        icp_pkg::ST_RACK: begin
          // master ack keeps burst going, nack ends it
          if (scl_rise) begin
            more_nxt = ~sda_hi;
          end else if (scl_fall) begin
            if (more_r) begin
              oe_n_nxt = tx[7];
              shf_nxt  = {tx[6:0], 1'b0};
              st_nxt   = icp_pkg::ST_RDAT;
            end else begin
              st_nxt = icp_pkg::ST_IGN;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r     <= icp_pkg::ST_IDLE;
      bcnt_r   <= 4'h0;
      shf_r    <= 8'h00;
      ptr_r    <= icp_pkg::PTR_RESET;
      rw_r     <= 1'b0;
      first_r  <= 1'b0;
      preset_r <= 1'b0;
      sthi_r   <= 1'b0;
      more_r   <= 1'b0;
      oe_n_r   <= 1'b1;
      pwr_r    <= icp_pkg::PWR_RESET;
    end else begin
      st_r     <= st_nxt;
      bcnt_r   <= bcnt_nxt;
      shf_r    <= shf_nxt;
      ptr_r    <= ptr_nxt;
      rw_r     <= rw_nxt;
      first_r  <= first_nxt;
      preset_r <= preset_nxt;
      sthi_r   <= sthi_nxt;
      more_r   <= more_nxt;
      oe_n_r   <= oe_n_nxt;
      pwr_r    <= pwr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power distribution
  // ----------------------------------------------------------------
  icp_pkg::icp_power_t pst_r, pst_nxt;
  logic                on, mono;

  // enables decoded into block powers, all gated by shutdown
  always_comb begin
    on   = pwr_r.power_down_ctl;     // low = low-power shutdown
    mono = headphone_amp_mode[0];    // mono modes drop right amp
    pst_nxt.shutdown          = ~on;
    // left line preamp and its routing
    pst_nxt.left_line_preamp  = on & pwr_r.left_line_input_enable;
    pst_nxt.line_l_to_r_mix   = on & pwr_r.left_line_input_enable &
                                ~pwr_r.right_line_input_enable;
    pst_nxt.line_l_to_r_hp    = pst_nxt.line_l_to_r_mix & ~mono;
    pst_nxt.right_line_preamp = on & pwr_r.right_line_input_enable;
    // left dac feeds right amp when right dac off and not in a mono mode
    pst_nxt.left_dac          = on & pwr_r.left_dac_enable;
    pst_nxt.dac_l_to_r_hp     = on & pwr_r.left_dac_enable &
                                ~pwr_r.right_dac_enable & ~mono;
    // right dac needs left dac enabled
    pst_nxt.right_dac         = pst_nxt.left_dac &
                                pwr_r.right_dac_enable;
    // right adc needs left adc enabled
    pst_nxt.left_adc          = on & pwr_r.left_adc_enable;
    pst_nxt.right_adc         = pst_nxt.left_adc &
                                pwr_r.right_adc_enable;
    // amplifiers follow line and dac sources
    pst_nxt.hp_left_amp       = on & (pwr_r.left_line_input_enable |
                                      pwr_r.left_dac_enable);
    pst_nxt.hp_right_amp      = on & ~mono &
                                (pwr_r.left_line_input_enable |
                                 pwr_r.right_line_input_enable |
                                 pwr_r.left_dac_enable);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pst_r <= '0;
    end else begin
      pst_r <= pst_nxt;
    end
  end

  // open drain: only ever pull low, enable is active low
  assign sda_out       = 1'b0;
  assign sda_oe_n      = oe_n_r;
  assign power_control = pwr_r;
  assign power_state   = pst_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  foreign_release_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == icp_pkg::ST_IGN && !start_p) |=> oe_n_r)
    else $error("sda driven while ignoring bus");

  ack_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == icp_pkg::ST_ACK) |-> !oe_n_r)
    else $error("acknowledge released early");

  start_addr_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    start_p |=> (st_r == icp_pkg::ST_ADDR && bcnt_r == 4'h0))
    else $error("start did not open address phase");

  stop_idle_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (stop_p && !sthi_r) |=> (st_r == icp_pkg::ST_IDLE && oe_n_r))
    else $error("stop not honoured");

  read_ptr_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_addr_hit |=> (ptr_r == icp_pkg::PTR_RESET) ##1
                    (st_r == icp_pkg::ST_ACK))
    else $error("read pointer not reset");

  write_step_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_stb |=> (ptr_r == $past(ptr_r) + 8'h01))
    else $error("pointer did not step after write");

  read_stable_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == icp_pkg::ST_RDAT && scl_hi && $past(scl_hi) &&
     $past(st_r) == icp_pkg::ST_RDAT) |-> $stable(oe_n_r))
    else $error("read data moved while scl high");

  rsvd_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !pwr_r[icp_pkg::PWR_RSVD_BIT])
    else $error("reserved power bit set");

  shutdown_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !pwr_r.power_down_ctl [*2] |->
      (pst_r.shutdown && !pst_r.hp_left_amp && !pst_r.left_dac))
    else $error("power left on in shutdown");

  dac_pair_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pst_r.right_dac |-> (pst_r.left_dac && !pst_r.dac_l_to_r_hp))
    else $error("right dac without left dac");

endmodule

// ===== core/icp_line_sync.sv
// line synchroniser and bus condition detector for scl and sda
module icp_line_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  output logic      scl_hi,
  output logic      sda_hi,
  output logic      start_pulse,
  output logic      stop_pulse,
  output logic      scl_rise,
  output logic      scl_fall
);

  logic [1:0] meta_r, meta_nxt;  // first stage, read only by sync_r
  logic [1:0] sync_r, sync_nxt;
  logic [1:0] last_r, last_nxt;

  // ----------------------------------------------------------------
  // two-stage capture plus one history stage, lines idle high
  // ----------------------------------------------------------------
  always_comb begin
    meta_nxt = {scl_pin, sda_pin};
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      last_r <= 2'h3;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // edges and conditions seen only on settled samples
  assign scl_hi      = sync_r[1];
  assign sda_hi      = sync_r[0];
  assign scl_rise    = sync_r[1] & ~last_r[1];
  assign scl_fall    = ~sync_r[1] & last_r[1];
  assign start_pulse = sync_r[1] & last_r[1] & last_r[0] & ~sync_r[0];
  assign stop_pulse  = sync_r[1] & last_r[1] & ~last_r[0] & sync_r[0];

endmodule

// ===== core/icp_pkg.sv
// shared constants and types of the two-wire control port
package icp_pkg;

  // ----------------------------------------------------------------
  // bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR   = 7'h18; // 0011000
  localparam logic [7:0] ADDR_BYTE_WR = 8'h30;
  localparam logic [7:0] ADDR_BYTE_RD = 8'h31;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [7:0] REG_PWR      = 8'h17;
  localparam logic [7:0] REG_REV      = 8'hff;
  localparam logic [7:0] PWR_RESET    = 8'h00;
  localparam logic [7:0] PWR_WMASK    = 8'hef; // bit 4 always zero
  localparam logic [7:0] REV_DEFAULT  = 8'h5a; // arbitrary value
  localparam int         PWR_RSVD_BIT = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ   = 125000000;
  localparam int SCL_MAX_KHZ   = 400;
  localparam int SCL_HALF_CYC  = CORE_CLK_HZ / (2 * SCL_MAX_KHZ * 1000);
  localparam int MIN_HALF_CYC  = 4; // sync latency plus one decision

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WDAT, ST_RDAT, ST_RACK, ST_IGN
  } icp_state_t;

  typedef struct packed {
    logic power_down_ctl;
    logic left_line_input_enable;
    logic right_line_input_enable;
    logic zero_bit;
    logic left_dac_enable;
    logic right_dac_enable;
    logic left_adc_enable;
    logic right_adc_enable;
  } icp_pwr_reg_t;

  typedef struct packed {
    logic shutdown;
    logic left_line_preamp;
    logic right_line_preamp;
    logic left_dac;
    logic right_dac;
    logic left_adc;
    logic right_adc;
    logic hp_left_amp;
    logic hp_right_amp;
    logic line_l_to_r_mix;
    logic line_l_to_r_hp;
    logic dac_l_to_r_hp;
  } icp_power_t;

endpackage

// ===== sim/icp_i2c_master.sv
// bus master model that drives scl and sda of the control port
module icp_i2c_master (
  input  wire logic core_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // line drive, 160 ns bus clock cut into 40 ns quarters
  // ------------------------------------------------------------
  // both lines released and idle high at time zero
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // moves on the falling core edge, away from the sampling edge
  task automatic qtr();
    repeat (5) @(negedge core_clk);
  endtask

  task automatic start();
    sda_drv = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_drv = 1'b0;
    qtr();
    scl = 1'b0;
    qtr();
  endtask

  // stop placed inside the start's own high pulse
  task automatic start_glitch();
    sda_drv = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_drv = 1'b0;
    qtr();
    sda_drv = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_drv = 1'b1;
    qtr();
  endtask

  // sda changes only while scl is low, msb first
  task automatic send_bits(input logic [7:0] d, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sda_drv = d[i];
      qtr();
      scl = 1'b1;
      qtr();
      qtr();
      scl = 1'b0;
      qtr();
    end
  endtask

  // taken at the rising scl edge, own driver released
  task automatic recv_bit(output logic b);
    sda_drv = 1'b1;
    qtr();
    b = sda_w;
    scl = 1'b1;
    qtr();
    qtr();
    scl = 1'b0;
    qtr();
  endtask

  // byte then ninth clock, a low line means acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    send_bits(d, 8);
    recv_bit(b);
    ack = ~b;
  endtask

  // ack every read byte except the last one
  task automatic rd_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      recv_bit(d[i]);
    end
    send_bits({last, 7'h00}, 1);
  endtask
endmodule

// ===== sim/tb_icp_ctrl_port.sv
// self-checking bench for the two-wire control port
module tb_icp_ctrl_port;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] REV_CODE = 8'h3c; // arbitrary value

  logic                  core_clk;
  logic                  rst_n;
  logic                  scl;
  logic                  sda_drv;
  logic                  sda_out;
  logic                  sda_oe_n;
  logic                  sda_w;
  logic [2:0]            hp_mode;
  icp_pkg::icp_pwr_reg_t pwr_reg;
  icp_pkg::icp_power_t   pwr_state;
  int                    err_count = 0;
  int                    checks = 0;

  // open-drain wire with pull-up: low whenever a party pulls
  assign sda_w = sda_drv & (sda_oe_n | sda_out);

  icp_ctrl_port #(.REVISION_CODE(REV_CODE)) dut_u (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .scl_in             (scl),
    .sda_in             (sda_w),
    .sda_out            (sda_out),
    .sda_oe_n           (sda_oe_n),
    .headphone_amp_mode (hp_mode),
    .power_control      (pwr_reg),
    .power_state        (pwr_state)
  );

  icp_i2c_master mst_u (
    .core_clk (core_clk),
    .sda_w    (sda_w),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  // ------------------------------------------------------------
  // clock, checks and bus tasks
  // ------------------------------------------------------------
  // 125 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_ack(input logic got, input logic exp, input string s);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string s);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic cmp_state(input icp_pkg::icp_power_t got,
                           input icp_pkg::icp_power_t exp, input string s);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    mst_u.wr_byte(d, a);
    cmp_ack(a, exp_ack, "ack");
  endtask

  // full write frame, then time for the outputs to settle
  task automatic wr_regs(input logic [7:0] ptr, input logic [7:0] q[$]);
    mst_u.start();
    send(icp_pkg::ADDR_BYTE_WR, 1'b1);
    send(ptr, 1'b1);
    foreach (q[i]) begin
      send(q[i], 1'b1);
    end
    mst_u.stop();
    repeat (4) @(negedge core_clk);
  endtask

  // optional pointer preset, then a read burst ended by nack
  task automatic rd_regs(input logic pre, input logic [7:0] ptr,
                         input logic [7:0] want[$]);
    logic [7:0] d;
    if (pre) begin
      mst_u.start();
      send(icp_pkg::ADDR_BYTE_WR, 1'b1);
      send(ptr, 1'b1);
    end
    mst_u.start();
    send(icp_pkg::ADDR_BYTE_RD, 1'b1);
    foreach (want[i]) begin
      mst_u.rd_byte(d, i == want.size() - 1);
      cmp_byte(d, want[i], "read data");
    end
    mst_u.stop();
  endtask

  task automatic pwr_case(input logic [2:0] m, input logic [7:0] v,
                          input logic [11:0] e);
    hp_mode = m;
    // software cycles shutdown around each configuration change
    wr_regs(icp_pkg::REG_PWR, '{v & 8'h7f});
    cmp_state(pwr_state, 12'h800, "toggle off");
    wr_regs(icp_pkg::REG_PWR, '{v});
    cmp_byte(pwr_reg, v & icp_pkg::PWR_WMASK, "power reg");
    cmp_state(pwr_state, e, "power state");
  endtask

  // hang guard, well above the roughly 300 us the tests need
  initial begin
    #600us;
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out();
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    rst_n   = 1'b0;
    hp_mode = 3'h0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    cmp_byte(pwr_reg, icp_pkg::PWR_RESET, "reset reg");
    cmp_state(pwr_state, 12'h800, "reset state");
    cmp_ack(sda_oe_n, 1'b1, "idle sda");
    $display("test reset done");
    wr_regs(icp_pkg::REG_PWR, '{8'hff});
    cmp_byte(pwr_reg, 8'hef, "zero bit");
    rd_regs(1'b1, icp_pkg::REG_PWR, '{8'hef, 8'h00});
    $display("test write readback done");
    // pointer left at 0xff, so a plain read shows the restart
    rd_regs(1'b1, 8'hfe, '{8'h00});
    rd_regs(1'b0, 8'h00, '{8'h00, 8'h00});
    rd_regs(1'b1, icp_pkg::REG_REV, '{REV_CODE, 8'h00});
    // writes stay at or below the power register
    wr_regs(8'h16, '{8'h00});
    cmp_byte(pwr_reg, 8'hef, "side write");
    rd_regs(1'b1, icp_pkg::REG_REV, '{REV_CODE});
    $display("test pointer and revision done");
    wr_regs(8'h16, '{8'h11, 8'h8c});
    cmp_byte(pwr_reg, 8'h8c, "burst");
    mst_u.start();
    send(8'h32, 1'b0);
    send(icp_pkg::REG_PWR, 1'b0);
    send(8'h00, 1'b0);
    mst_u.stop();
    cmp_byte(pwr_reg, 8'h8c, "foreign");
    mst_u.start();
    send(icp_pkg::ADDR_BYTE_WR, 1'b1);
    send(icp_pkg::REG_PWR, 1'b1);
    mst_u.send_bits(8'h00, 4);
    mst_u.stop();
    cmp_byte(pwr_reg, 8'h8c, "cut byte");
    mst_u.start_glitch();
    send(icp_pkg::ADDR_BYTE_WR, 1'b1);
    send(icp_pkg::REG_PWR, 1'b1);
    send(8'h80, 1'b1);
    mst_u.stop();
    repeat (4) @(negedge core_clk);
    cmp_byte(pwr_reg, 8'h80, "glitch frame");
    $display("test framing done");
    for (int m = 0; m < 8; m++) begin
      pwr_case(3'(m), 8'hc0, m[0] ? 12'h414 : 12'h41e);
      pwr_case(3'(m), 8'ha0, m[0] ? 12'h200 : 12'h208);
    end
    pwr_case(3'h0, 8'h88, 12'h119);
    pwr_case(3'h1, 8'h88, 12'h110);
    pwr_case(3'h0, 8'h8c, 12'h198);
    pwr_case(3'h0, 8'h84, 12'h000);
    pwr_case(3'h0, 8'h83, 12'h060);
    pwr_case(3'h0, 8'h81, 12'h000);
    pwr_case(3'h0, 8'h00, 12'h800);
    $display("test power management done");
    close_out();
  end
endmodule
